// *** verilog/mcu_exec_pkg.sv ***
package mcu_exec_pkg;

	// Register map, byte addresses on the APB side
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] ACCUM_OFF = 12'h004;
	localparam logic [11:0] STATUS_OFF = 12'h008;
	localparam logic [11:0] PAGE_OFF = 12'h00C;
	localparam logic [11:0] PC_OFF = 12'h010;
	localparam logic [11:0] WDOG_OFF = 12'h014;
	localparam logic [11:0] STACK_OFF = 12'h018;
	// File array window: paddr[11:9] selects it, paddr[8:2] is the register number
	localparam logic [2:0] FILE_SEL = 3'h1;

	// Field positions
	localparam int RUN_BIT = 0;
	localparam int C_BIT = 0;
	localparam int DC_BIT = 1;
	localparam int Z_BIT = 2;
	localparam int PD_BIT = 3;
	localparam int TO_BIT = 4;
	localparam int PAGE_HI_BIT = 4;
	localparam int PAGE_LO_BIT = 3;
	localparam int DEST_BIT = 7;

	// Reset values
	localparam logic [4:0] STATUS_RST = 5'h18;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [13:0] NOP_WORD = 14'h0000;

	// Storage depths
	localparam int FILE_DEPTH = 128;
	localparam int STACK_DEPTH = 8;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ADD_REG = 5'h01,
		OP_AND_REG = 5'h02,
		OP_CLR_REG = 5'h03,
		OP_CLR_ACC = 5'h04,
		OP_COMPLEMENT = 5'h05,
		OP_DECREMENT = 5'h06,
		OP_DEC_SKIP = 5'h07,
		OP_INCREMENT = 5'h08,
		OP_BIT_CLR = 5'h09,
		OP_BIT_SET = 5'h0A,
		OP_SKIP_CLR = 5'h0B,
		OP_SKIP_SET = 5'h0C,
		OP_CALL = 5'h0D,
		OP_BRANCH = 5'h0E,
		OP_WDT_CLR = 5'h0F,
		OP_ADD_LIT = 5'h10,
		OP_AND_LIT = 5'h11
	} op_t;

	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROC = 2'b10,
		PH_WRITE = 2'b11
	} phase_t;

	typedef struct packed {
		op_t op;
		logic [7:0] acc;
		logic [7:0] opnd;
		logic [2:0] bitsel;
		logic dest;
	} alu_in_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
		logic z;
		logic skip;
		logic to_acc;
		logic to_file;
		logic upd_cdc;
		logic upd_z;
	} alu_out_t;

	// Instruction word to operation; unlisted words run as a no-operation
	function automatic op_t decode_op(input logic [13:0] w);
		casez (w)
			14'b00_0111_????_????: return OP_ADD_REG;
			14'b00_0101_????_????: return OP_AND_REG;
			14'b00_0001_1???_????: return OP_CLR_REG;
			14'b00_0001_0???_????: return OP_CLR_ACC;
			14'b00_1001_????_????: return OP_COMPLEMENT;
			14'b00_0011_????_????: return OP_DECREMENT;
			14'b00_1011_????_????: return OP_DEC_SKIP;
			14'b00_1010_????_????: return OP_INCREMENT;
			14'b00_0000_0110_0100: return OP_WDT_CLR;
			14'b01_00??_????_????: return OP_BIT_CLR;
			14'b01_01??_????_????: return OP_BIT_SET;
			14'b01_10??_????_????: return OP_SKIP_CLR;
			14'b01_11??_????_????: return OP_SKIP_SET;
			14'b10_0???_????_????: return OP_CALL;
			14'b10_1???_????_????: return OP_BRANCH;
			14'b11_111?_????_????: return OP_ADD_LIT;
			14'b11_1001_????_????: return OP_AND_LIT;
			default: return OP_NOP;
		endcase
	endfunction : decode_op

	// One-hot mask for a bit number 0 to 7
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		return 8'h01 << sel;
	endfunction : bit_mask

endpackage : mcu_exec_pkg

// *** verilog/exec_alu.sv ***
`timescale 1ns/10ps
module exec_alu
	import mcu_exec_pkg::*;
(
	input wire alu_in_t alu_in,
	output alu_out_t alu_out
);

	// Result, flags, skip and destination for the decoded operation
	always_comb begin
		logic [8:0] sum;
		logic [4:0] nib;
		logic [7:0] mask;
		sum = {1'b0, alu_in.acc} + {1'b0, alu_in.opnd};
		nib = {1'b0, alu_in.acc[3:0]} + {1'b0, alu_in.opnd[3:0]};
		mask = bit_mask(alu_in.bitsel);
		alu_out = '0;
		case (alu_in.op)
			OP_ADD_REG, OP_ADD_LIT: begin
				alu_out.res = sum[7:0];
				alu_out.c = sum[8];
				alu_out.dc = nib[4];
				alu_out.upd_cdc = 1'b1;
				alu_out.upd_z = 1'b1;
			end
			OP_AND_REG, OP_AND_LIT: begin
				alu_out.res = alu_in.acc & alu_in.opnd;
				alu_out.upd_z = 1'b1;
			end
			OP_CLR_REG, OP_CLR_ACC: begin
				alu_out.res = 8'h00;
				alu_out.upd_z = 1'b1;
			end
			OP_COMPLEMENT: begin
				alu_out.res = ~alu_in.opnd;
				alu_out.upd_z = 1'b1;
			end
			OP_DECREMENT: begin
				alu_out.res = alu_in.opnd - 8'h01;
				alu_out.upd_z = 1'b1;
			end
			OP_INCREMENT: begin
				alu_out.res = alu_in.opnd + 8'h01;
				alu_out.upd_z = 1'b1;
			end
			OP_DEC_SKIP: begin
				// No flag update here, only the skip
				alu_out.res = alu_in.opnd - 8'h01;
				alu_out.skip = (alu_in.opnd == 8'h01);
			end
			OP_BIT_CLR: alu_out.res = alu_in.opnd & ~mask;
			OP_BIT_SET: alu_out.res = alu_in.opnd | mask;
			OP_SKIP_CLR: alu_out.skip = ((alu_in.opnd & mask) == 8'h00);
			OP_SKIP_SET: alu_out.skip = ((alu_in.opnd & mask) != 8'h00);
			default: alu_out = '0;
		endcase
		alu_out.z = (alu_out.res == 8'h00);
		// Byte operations follow the destination bit, the rest are fixed
		if (alu_in.op inside {OP_ADD_REG, OP_AND_REG, OP_COMPLEMENT, OP_DECREMENT,
			OP_DEC_SKIP, OP_INCREMENT}) begin
			alu_out.to_acc = !alu_in.dest;
			alu_out.to_file = alu_in.dest;
		end else begin
			alu_out.to_acc = alu_in.op inside {OP_ADD_LIT, OP_AND_LIT, OP_CLR_ACC};
			alu_out.to_file = alu_in.op inside {OP_CLR_REG, OP_BIT_CLR, OP_BIT_SET};
		end
	end

endmodule : exec_alu

// *** verilog/mcu_exec_core.sv ***
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
// Overview of operation
// - Add register: accumulator plus file register, update carry, digit carry, zero.
// - AND register: accumulator AND file register, only zero flag changes.
// - Destination bit 0 sends result to accumulator, 1 to file register.
// - Four phases per cycle: decode, operand read, process, write.
// - Bit clear forces the selected bit to zero, flags untouched.
// - Bit set forces the selected bit to one, flags untouched.
// - Skip-if-clear skips the next instruction when the bit is 0.
// - Skip-if-set skips the next instruction when the bit is 1.
// - A taken skip replaces the fetched instruction with a no-operation cycle.
// - Call pushes incremented PC, then loads the 11-bit literal into PC.
// - Branch loads the 11-bit literal into PC, flags untouched.
// - Call and branch take PC bits 12:11 from page latch bits 4:3.
// - Call and branch take two cycles, the second a no-operation.
// - Clear register writes zero to the file register and sets zero flag.
// - Clear accumulator writes zero to it and sets zero flag.
// - Watchdog clear zeroes count and prescaler, sets timeout and powerdown.
// - The file address field is a 7-bit register number, 0 to 127.
// - Each instruction cycle lasts four clock periods.
// - Add literal adds the 8-bit literal to accumulator, updates three flags.
// - AND literal ANDs the literal into accumulator, only zero flag changes.
module mcu_exec_core
	import mcu_exec_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [12:0] prog_addr,
	input wire logic [13:0] prog_data,
	output logic wdt_clear_pulse
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic run_q;
	phase_t phase_q;
	logic [12:0] pc_q;
	logic [13:0] fetch_q;
	logic [13:0] ir_q;
	logic flush_q;
	logic [7:0] opnd_q;
	alu_out_t alu_q;
	alu_in_t alu_in;
	alu_out_t alu_out;
	logic [7:0] acc_q;
	logic [4:0] status_q;
	logic [7:0] page_q;
	logic [7:0] file_mem [FILE_DEPTH];
	logic [12:0] stack_mem [STACK_DEPTH];
	logic [2:0] sp_q;
	logic [12:0] stack_top;
	logic [7:0] wdt_q;
	logic [7:0] wdt_pre_q;
	logic wdt_clr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_data;
	op_t cur_op;
	logic [6:0] file_idx;
	logic wr_phase;
	logic is_lit;
	logic pc_load;
	logic apb_setup;
	logic apb_wr;

	// Address decode shared by the read mux, the write path and the error answer
	function automatic logic file_hit(input logic [11:0] a);
		return a[11:9] == FILE_SEL;
	endfunction : file_hit

	function automatic logic reg_hit(input logic [11:0] a);
		return file_hit(a) || a inside {CTRL_OFF, ACCUM_OFF, STATUS_OFF, PAGE_OFF, PC_OFF,
			WDOG_OFF, STACK_OFF};
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////////////////////
	// Decode and sequencing

	// Decode runs straight off the instruction register all cycle long
	assign cur_op = decode_op(ir_q);
	assign file_idx = ir_q[6:0];
	assign wr_phase = run_q && (phase_q == PH_WRITE);
	assign is_lit = (cur_op == OP_ADD_LIT) || (cur_op == OP_AND_LIT);
	assign pc_load = wr_phase && ((cur_op == OP_CALL) || (cur_op == OP_BRANCH));
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;

	// Four clock periods per instruction cycle; stops in place while halted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= PH_DECODE;
		end else if (run_q) begin
			case (phase_q)
				PH_DECODE: phase_q <= PH_READ;
				PH_READ: phase_q <= PH_PROC;
				PH_PROC: phase_q <= PH_WRITE;
				PH_WRITE: phase_q <= PH_DECODE;
				default: phase_q <= PH_DECODE;
			endcase
		end
	end

	// Fetch of the next word overlaps execution; it lands in the last phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= PC_RST;
			fetch_q <= NOP_WORD;
		end else if (wr_phase) begin
			fetch_q <= prog_data;
			if (pc_load) begin
				pc_q <= {page_q[PAGE_HI_BIT:PAGE_LO_BIT], ir_q[10:0]};
			end else begin
				pc_q <= pc_q + 13'h0001;
			end
		end
	end

	assign prog_addr = pc_q;

	// A flushed word is swapped for a no-operation so prefetch never runs stale code
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ir_q <= NOP_WORD;
			flush_q <= 1'b0;
		end else if (run_q && (phase_q == PH_DECODE)) begin
			ir_q <= flush_q ? NOP_WORD : fetch_q;
			flush_q <= 1'b0;
		end else if (wr_phase) begin
			flush_q <= pc_load || alu_q.skip;
		end
	end

	// Operand read in the second phase, result latched in the third
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			opnd_q <= 8'h00;
			alu_q <= '0;
		end else begin
			if (run_q && (phase_q == PH_READ)) begin
				opnd_q <= file_mem[file_idx];
			end
			if (run_q && (phase_q == PH_PROC)) begin
				alu_q <= alu_out;
			end
		end
	end

	// Literal operations take their operand from the instruction itself
	always_comb begin
		alu_in.op = cur_op;
		alu_in.acc = acc_q;
		alu_in.opnd = is_lit ? ir_q[7:0] : opnd_q;
		alu_in.bitsel = ir_q[9:7];
		alu_in.dest = ir_q[DEST_BIT];
	end

	exec_alu u_alu (
		.alu_in(alu_in),
		.alu_out(alu_out)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Architectural state; the core wins over a same-cycle bus write

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_q <= ACC_RST;
		end else if (wr_phase && alu_q.to_acc) begin
			acc_q <= alu_q.res;
		end else if (apb_wr && (paddr == ACCUM_OFF)) begin
			acc_q <= pwdata[7:0];
		end
	end

	// Core flag changes come only in the write phase, and only those the operation owns; a bus write loads them otherwise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= STATUS_RST;
		end else if (wr_phase && (alu_q.upd_cdc || alu_q.upd_z || (cur_op == OP_WDT_CLR))) begin
			if (alu_q.upd_cdc) begin
				status_q[C_BIT] <= alu_q.c;
				status_q[DC_BIT] <= alu_q.dc;
			end
			if (alu_q.upd_z) begin
				status_q[Z_BIT] <= alu_q.z;
			end
			if (cur_op == OP_WDT_CLR) begin
				status_q[TO_BIT] <= 1'b1;
				status_q[PD_BIT] <= 1'b1;
			end
		end else if (apb_wr && (paddr == STATUS_OFF)) begin
			status_q <= pwdata[4:0];
		end
	end

	// Software-owned controls
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_q <= 1'b0;
			page_q <= PAGE_RST;
		end else if (apb_wr) begin
			if (paddr == CTRL_OFF) begin
				run_q <= pwdata[RUN_BIT];
			end
			if (paddr == PAGE_OFF) begin
				page_q <= pwdata[7:0];
			end
		end
	end

	// File array has no reset; software loads it through the window
	always_ff @(posedge clk) begin
		if (wr_phase && alu_q.to_file) begin
			file_mem[file_idx] <= alu_q.res;
		end else if (apb_wr && file_hit(paddr)) begin
			file_mem[paddr[8:2]] <= pwdata[7:0];
		end
	end

	// Eight-level stack wraps silently on overflow; nothing here pops it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_q <= 3'h0;
		end else if (pc_load && (cur_op == OP_CALL)) begin
			sp_q <= sp_q + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (pc_load && (cur_op == OP_CALL)) begin
			stack_mem[sp_q] <= pc_q;
		end
	end

	assign stack_top = stack_mem[sp_q - 3'h1];

	// Watchdog count advances once per prescaler wrap while running
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdt_q <= 8'h00;
			wdt_pre_q <= 8'h00;
			wdt_clr_q <= 1'b0;
		end else begin
			wdt_clr_q <= wr_phase && (cur_op == OP_WDT_CLR);
			if (wr_phase && (cur_op == OP_WDT_CLR)) begin
				wdt_q <= 8'h00;
				wdt_pre_q <= 8'h00;
			end else if (run_q) begin
				wdt_pre_q <= wdt_pre_q + 8'h01;
				if (wdt_pre_q == 8'hFF) begin
					wdt_q <= wdt_q + 8'h01;
				end
			end
		end
	end

	assign wdt_clear_pulse = wdt_clr_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle

	always_comb begin
		rd_data = 32'h0000_0000;
		if (file_hit(paddr)) begin
			rd_data[7:0] = file_mem[paddr[8:2]];
		end else begin
			case (paddr)
				CTRL_OFF: rd_data[RUN_BIT] = run_q;
				ACCUM_OFF: rd_data[7:0] = acc_q;
				STATUS_OFF: rd_data[4:0] = status_q;
				PAGE_OFF: rd_data[7:0] = page_q;
				PC_OFF: rd_data[12:0] = pc_q;
				WDOG_OFF: rd_data[7:0] = wdt_q;
				STACK_OFF: rd_data[12:0] = stack_top;
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_q <= rd_data;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_hit(paddr);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [8:0] chk_sum;
	assign chk_sum = {1'b0, acc_q} + {1'b0, opnd_q};

	property p_phase_seq;
		(run_q && phase_q == PH_DECODE) ##1 run_q [*2] |=> phase_q == PH_WRITE;
	endproperty
	a_phase_seq: assert property (p_phase_seq) else $error("phase walk broken");

	property p_add_flags;
		(run_q && phase_q == PH_PROC && cur_op == OP_ADD_REG) ##1 run_q
			|=> status_q[C_BIT] == $past(chk_sum[8], 2)
			&& status_q[Z_BIT] == $past(chk_sum[7:0] == 8'h00, 2);
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

	property p_and_zero;
		(run_q && phase_q == PH_PROC && cur_op == OP_AND_REG) ##1 run_q
			|=> status_q[Z_BIT] == $past((acc_q & opnd_q) == 8'h00, 2);
	endproperty
	a_and_zero: assert property (p_and_zero) else $error("and zero flag wrong");

	property p_dest_file;
		(wr_phase && cur_op == OP_ADD_REG && ir_q[DEST_BIT])
			|=> file_mem[$past(file_idx)] == $past(alu_q.res) && acc_q == $past(acc_q);
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("result not routed to file");

	property p_bit_clear;
		(wr_phase && cur_op == OP_BIT_CLR) |=> !file_mem[$past(file_idx)][$past(ir_q[9:7])];
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit not cleared");

	property p_bit_set;
		(wr_phase && cur_op == OP_BIT_SET) |=> file_mem[$past(file_idx)][$past(ir_q[9:7])];
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit not set");

	property p_skip_nop;
		(wr_phase && alu_q.skip) ##1 run_q |=> ir_q == NOP_WORD;
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("skip did not insert nop");

	property p_call_target;
		(wr_phase && cur_op == OP_CALL) |=> stack_top == $past(pc_q)
			&& pc_q == {$past(page_q[PAGE_HI_BIT:PAGE_LO_BIT]), $past(ir_q[10:0])};
	endproperty
	a_call_target: assert property (p_call_target) else $error("call target wrong");

	property p_branch_nop;
		(wr_phase && cur_op == OP_BRANCH) ##1 run_q |=> ir_q == NOP_WORD;
	endproperty
	a_branch_nop: assert property (p_branch_nop) else $error("branch second cycle not nop");

	property p_clr_reg;
		(wr_phase && cur_op == OP_CLR_REG) |=> status_q[Z_BIT] && file_mem[$past(file_idx)] == 8'h00;
	endproperty
	a_clr_reg: assert property (p_clr_reg) else $error("clear register wrong");

	property p_wdt_clr;
		(wr_phase && cur_op == OP_WDT_CLR) |=> wdt_q == 8'h00 && wdt_pre_q == 8'h00
			&& status_q[TO_BIT] && status_q[PD_BIT] && wdt_clear_pulse;
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear wrong");

	c_call: cover property (wr_phase && cur_op == OP_CALL);
	c_skip: cover property (wr_phase && alu_q.skip);
	c_add_carry: cover property (wr_phase && cur_op == OP_ADD_REG && alu_q.c);
	c_apb_write: cover property (apb_wr && file_hit(paddr));

endmodule : mcu_exec_core

// *** dv/prog_mem.sv ***
`timescale 1ns/10ps
module prog_mem
	import mcu_exec_pkg::*;
(
	input wire logic [12:0] prog_addr,
	output logic [13:0] prog_data
);
	// Full 13-bit space so paged targets land on real words
	logic [13:0] mem [0:8191];

	// Preload no-operations; the bench patches words only while halted
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = NOP_WORD;
		end
	end

	// Asynchronous read, settled well before the fetch edge
	assign prog_data = mem[prog_addr];
endmodule : prog_mem

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
	import mcu_exec_pkg::*;
;
	logic clk;
	logic resetn;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [12:0] prog_addr;
	logic [13:0] prog_data;
	logic wdt_clear_pulse;
	logic [12:0] last_pa;
	logic [31:0] r;
	logic e;
	int fails;
	int samples_checked;
	int pulses;
	int gap;
	bit running;

	mcu_exec_core mcu_exec_core_i (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
		.wdt_clear_pulse(wdt_clear_pulse));
	prog_mem prog_mem_i (.prog_addr(prog_addr), .prog_data(prog_data));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end

	// Fetch spacing: only counted inside a run, halting freezes the phase
	always @(posedge clk) begin
		if (!resetn || !running) begin
			gap <= -1;
		end else if (prog_addr !== last_pa) begin
			if (gap > 0) check(gap % 4 == 0, 1'b1);
			gap <= 1;
		end else if (gap >= 0) begin
			gap <= gap + 1;
		end
		last_pa <= prog_addr;
	end

	// Watchdog-clear pulses seen at the port
	always @(posedge clk) begin
		if (wdt_clear_pulse === 1'b1) pulses++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus and program helpers
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rdata, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		rdata = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, r, e);
	endtask : wr

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0, r, e);
		check(r, exp);
	endtask : rd_chk

	function automatic logic [11:0] fa(input logic [6:0] f);
		return 12'h200 + {3'h0, f, 2'h0};
	endfunction : fa

	function automatic logic [13:0] fo(input logic [5:0] op, input logic d, input logic [6:0] f);
		return {op, d, f};
	endfunction : fo

	function automatic logic [13:0] fb(input logic [1:0] op, input logic [2:0] b,
		input logic [6:0] f);
		return {2'h1, op, b, f};
	endfunction : fb

	task rst();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
	endtask : rst

	// Loops end on a self-branch at an even address, so the PC toggles L and L+1
	task run_to(input logic [12:0] end_a);
		int n;
		n = 0;
		wr(CTRL_OFF, 32'h1);
		running = 1'b1;
		do begin
			apb(PC_OFF, 1'b0, 32'h0, r, e);
			n++;
		end while (r[12:1] !== end_a[12:1] && n < 300);
		if (n >= 300) check(r, {19'h0, end_a});
		repeat (12) @(posedge clk);
		running = 1'b0;
		wr(CTRL_OFF, 32'h0);
	endtask : run_to

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_regs();
		rst();
		rd_chk(CTRL_OFF, 32'h0);
		rd_chk(ACCUM_OFF, 32'h0);
		rd_chk(STATUS_OFF, {27'h0, STATUS_RST});
		rd_chk(PAGE_OFF, 32'h0);
		rd_chk(WDOG_OFF, 32'h0);
		wr(PC_OFF, 32'h1FFF);
		rd_chk(PC_OFF, 32'h0);
		apb(12'h01C, 1'b0, 32'h0, r, e);
		check(r, 32'h0);
		check(e, 1'b1);
	endtask : t_regs

	task t_arith();
		logic [13:0] p [5];
		rst();
		wr(fa(7'h7F), 32'hC2);
		wr(ACCUM_OFF, 32'h17);
		p = '{fo(6'h07, 1'b0, 7'h7F), fo(6'h05, 1'b1, 7'h7F), {6'h39, 8'h5F},
			{6'h3E, 8'hA7}, {3'h5, 11'h004}};
		for (int i = 0; i < 5; i++) prog_mem_i.mem[i] = p[i];
		run_to(13'h0004);
		rd_chk(fa(7'h7F), 32'hC0);
		rd_chk(ACCUM_OFF, 32'h0);
		rd_chk(STATUS_OFF, 32'h1F);
	endtask : t_arith

	task t_unary();
		logic [13:0] p [9];
		rst();
		wr(fa(7'h05), 32'h13);
		wr(fa(7'h06), 32'h01);
		wr(fa(7'h07), 32'hFF);
		wr(fa(7'h08), 32'h5A);
		wr(ACCUM_OFF, 32'h33);
		p = '{fo(6'h09, 1'b1, 7'h05), fo(6'h03, 1'b1, 7'h06), fo(6'h0A, 1'b0, 7'h07),
			{7'h03, 7'h08}, fo(6'h0A, 1'b1, 7'h05), fo(6'h09, 1'b0, 7'h08), 14'h017F,
			NOP_WORD, {3'h5, 11'h008}};
		for (int i = 0; i < 9; i++) prog_mem_i.mem[i] = p[i];
		run_to(13'h0008);
		rd_chk(fa(7'h05), 32'hED);
		rd_chk(fa(7'h06), 32'h00);
		rd_chk(fa(7'h07), 32'hFF);
		rd_chk(fa(7'h08), 32'h00);
		rd_chk(ACCUM_OFF, 32'h00);
		rd_chk(STATUS_OFF, 32'h1C);
	endtask : t_unary

	task t_bits();
		logic [13:0] p [15];
		rst();
		wr(STATUS_OFF, 32'h1D);
		wr(fa(7'h10), 32'hC7);
		wr(fa(7'h11), 32'h0A);
		wr(fa(7'h12), 32'h00);
		wr(fa(7'h13), 32'h02);
		p = '{fb(2'h0, 3'h7, 7'h10), fb(2'h1, 3'h7, 7'h11), fb(2'h2, 3'h7, 7'h10),
			fb(2'h1, 3'h0, 7'h12), fb(2'h3, 3'h7, 7'h11), fb(2'h1, 3'h1, 7'h12),
			fb(2'h2, 3'h1, 7'h11), fb(2'h1, 3'h2, 7'h12), fb(2'h3, 3'h3, 7'h10),
			fb(2'h1, 3'h3, 7'h12), fo(6'h0B, 1'b1, 7'h13), fb(2'h1, 3'h4, 7'h12),
			fo(6'h0B, 1'b1, 7'h13), fb(2'h1, 3'h5, 7'h12), {3'h5, 11'h00E}};
		for (int i = 0; i < 15; i++) prog_mem_i.mem[i] = p[i];
		run_to(13'h000E);
		rd_chk(fa(7'h10), 32'h47);
		rd_chk(fa(7'h11), 32'h8A);
		rd_chk(fa(7'h12), 32'h1C);
		rd_chk(fa(7'h13), 32'h00);
		rd_chk(STATUS_OFF, 32'h1D);
	endtask : t_bits

	task t_flow();
		rst();
		wr(PAGE_OFF, 32'h08);
		wr(STATUS_OFF, 32'h07);
		wr(ACCUM_OFF, 32'h55);
		pulses = 0;
		prog_mem_i.mem[0] = 14'h0064;
		prog_mem_i.mem[1] = {3'h4, 11'h122};
		prog_mem_i.mem[2] = 14'h0100;
		prog_mem_i.mem[13'h0922] = {3'h5, 11'h122};
		run_to(13'h0922);
		rd_chk(ACCUM_OFF, 32'h55);
		rd_chk(STATUS_OFF, 32'h1F);
		rd_chk(STACK_OFF, 32'h2);
		apb(PC_OFF, 1'b0, 32'h0, r, e);
		check({20'h0, r[12:1]}, 32'h491);
		check(pulses, 1);
	endtask : t_flow

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		running = 1'b0;
		fails = 0;
		samples_checked = 0;
		pulses = 0;
		t_regs();
		t_arith();
		t_unary();
		t_bits();
		t_flow();
		tally_and_finish();
	end
endmodule : tb_top
